//--- inc/dlf_pkg.sv
/*
 loop filter configuration constants: register offsets, field positions,
 reset values and state codes for the dpll loop filter config bank.
 assumes a plain address/strobe register port with 4-bit register indices.
*/
`default_nettype none
package dlf_pkg;
   // register indices on the plain port
   localparam logic [3:0] OFS_DECIM   = 4'h0;
   localparam logic [3:0] OFS_TRIM    = 4'h1;
   localparam logic [3:0] OFS_HOLD    = 4'h2;
   localparam logic [3:0] OFS_BW      = 4'h3;
   localparam logic [3:0] OFS_DAMP    = 4'h4;
   localparam logic [3:0] OFS_CTRL    = 4'h5;
   localparam logic [3:0] OFS_STATUS  = 4'h6;
   localparam logic [3:0] OFS_IRQ_ST  = 4'h7;
   localparam logic [3:0] OFS_IRQ_MSK = 4'h8;

   // reset values
   localparam logic [15:0] RST_DECIM = 16'h0036;
   localparam logic [15:0] RST_TRIM  = 16'h0000;
   localparam logic [15:0] RST_HOLD  = 16'h3800;
   localparam logic [15:0] RST_BW    = 16'h7058;
   localparam logic [15:0] RST_DAMP  = 16'h2901;
   localparam logic [15:0] RST_CTRL  = 16'h0001;

   // writable bit masks; reserved bits stay zero
   localparam logic [15:0] MSK_DECIM = 16'h007f;
   localparam logic [15:0] MSK_TRIM  = 16'h00ff;
   localparam logic [15:0] MSK_DAMP  = 16'h3f3f;
   localparam logic [15:0] MSK_CTRL  = 16'h0003;

   // control bit positions
   localparam int CTRL_AUTO_SEL = 0;
   localparam int CTRL_FREEZE   = 1;

   // saturation limit of the holdover coarse shift
   localparam logic [4:0] HOLD_COARSE_MAX = 5'h14;

   // interrupt bit positions
   localparam int IRQ_UNLOCK_RISE = 0;
   localparam int IRQ_STATE_CHG   = 1;
   localparam int IRQ_W           = 2;

   // loop state reported by the state machine outside this block
   typedef enum logic [1:0]
   {
      DLF_ST_FREERUN = 2'b00,
      DLF_ST_ACQUIRE = 2'b01,
      DLF_ST_NORMAL  = 2'b10,
      DLF_ST_HOLD    = 2'b11
   } dlf_loop_state_t;
endpackage
`default_nettype wire

//--- inc/dlf_sel_if.sv
/*
 interface joining the bank to its parameter selector.
 assumes both ends sit on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface dlf_sel_if;
   logic [15:0]               bw_cfg;
   logic [15:0]               damp_cfg;
   logic                      auto_sel;
   dlf_pkg::dlf_loop_state_t  loop_state;
   logic [4:0]                bw_coarse;
   logic [2:0]                bw_fine;
   logic [2:0]                damp_shift;
   logic [2:0]                damp_mult;
   logic                      acq_active;

   modport bank
   (
      output bw_cfg,
      output damp_cfg,
      output auto_sel,
      output loop_state,
      input  bw_coarse,
      input  bw_fine,
      input  damp_shift,
      input  damp_mult,
      input  acq_active
   );
   modport sel
   (
      input  bw_cfg,
      input  damp_cfg,
      input  auto_sel,
      input  loop_state,
      output bw_coarse,
      output bw_fine,
      output damp_shift,
      output damp_mult,
      output acq_active
   );
endinterface
`default_nettype wire

//--- logic/dlf_param_sel.sv
/*
 picks the acquire or locked bandwidth and damping set.
 assumes registered config inputs from the bank on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dlf_param_sel
(
   dlf_sel_if.sel  sel_io
);
   // acquire set only while auto switching is on and the loop acquires
   assign sel_io.acq_active = sel_io.auto_sel &&
      (sel_io.loop_state == dlf_pkg::DLF_ST_ACQUIRE);
   // two independent sets, one chosen at a time
   assign sel_io.bw_coarse  = sel_io.acq_active ?
      sel_io.bw_cfg[15:11] : sel_io.bw_cfg[7:3];
   assign sel_io.bw_fine    = sel_io.acq_active ?
      sel_io.bw_cfg[10:8]  : sel_io.bw_cfg[2:0];
   assign sel_io.damp_shift = sel_io.acq_active ?
      sel_io.damp_cfg[13:11] : sel_io.damp_cfg[5:3];
   assign sel_io.damp_mult  = sel_io.acq_active ?
      sel_io.damp_cfg[10:8]  : sel_io.damp_cfg[2:0];
endmodule
`default_nettype wire

//--- logic/dlf_cfg_bank.sv
/*
 configuration bank for the dpll loop filter: decimator, crystal trim,
 holdover, bandwidth and damping fields, loss-of-lock limit flag, and
 a sticky interrupt status with mask.
 assumes a same-clock register master and loop state inputs on ref_clk.
*/
// Local design decisions: the register offsets and strobed register access.
// What this block does
// - during a switch the 3-bit switch shift, default 3, sets decimation.
// - with hitless switching off the switch shift is ignored.
// - the 4-bit main shift, default 6, sets decimation; zero feeds through.
// - the crystal trim byte is a signed two's complement value.
// - the 5-bit holdover coarse shift, default 7, zero bypasses the filter.
// - holdover coarse values above 20 act as 20.
// - the 3-bit holdover fine multiplier, reset zero, zero bypasses too.
// - the 4-bit holdover history is instantaneous or 1 to 15 seconds.
// - the limit flag is high while the unlock count exceeds the threshold.
// - acquire uses coarse shift default 14 and fine multiplier default 0.
// - normal uses coarse shift default 11 and fine multiplier default 0.
// - acquire uses damping shift default 5 and multiplier default 1.
// - normal uses damping shift default 0 and multiplier default 1.
// - two independent parameter sets are kept.
// - with auto switching on, acquire uses the acquire set, else normal.
`timescale 1ns/1ps
`default_nettype none
module dlf_cfg_bank
(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [15:0]      reg_rdata,
   input  wire logic        hitless_en,
   input  wire logic        switch_active,
   input  wire logic [1:0]  loop_state_in,
   input  wire logic [7:0]  unlock_count,
   output logic [3:0]       decim_shift,
   output logic             decim_bypass,
   output logic signed [7:0] xtal_trim_val,
   output logic [4:0]       hold_filter_coarse,
   output logic [2:0]       hold_filter_fine,
   output logic             hold_filter_bypass,
   output logic [3:0]       hold_history_sec,
   output logic             unlock_limit_flag,
   output logic [4:0]       loop_bw_coarse,
   output logic [2:0]       loop_bw_fine,
   output logic [2:0]       loop_damp_shift,
   output logic [2:0]       loop_damp_mult,
   output logic             filter_freeze,
   output logic             irq
);
   localparam int IRQ_W_L = dlf_pkg::IRQ_W;
   logic [15:0] decim_reg;
   logic [15:0] trim_reg;
   logic [15:0] hold_reg;
   logic [15:0] bw_reg;
   logic [15:0] damp_reg;
   logic [15:0] ctrl_reg;
   logic [IRQ_W_L-1:0] irq_status;
   logic [IRQ_W_L-1:0] irq_mask;
   logic        limit_q;
   logic        acq_q;
   logic [15:0] next_rdata;

   dlf_sel_if sel_bus ();

   dlf_param_sel u_sel
   (
      .sel_io (sel_bus.sel)
   );

   // write decode shared by every register
   function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
      hit = (a == o);
   endfunction

   wire wr_decim = reg_wr && hit(reg_addr, dlf_pkg::OFS_DECIM);
   wire wr_trim  = reg_wr && hit(reg_addr, dlf_pkg::OFS_TRIM);
   wire wr_hold  = reg_wr && hit(reg_addr, dlf_pkg::OFS_HOLD);
   wire wr_bw    = reg_wr && hit(reg_addr, dlf_pkg::OFS_BW);
   wire wr_damp  = reg_wr && hit(reg_addr, dlf_pkg::OFS_DAMP);
   wire wr_ctrl  = reg_wr && hit(reg_addr, dlf_pkg::OFS_CTRL);
   wire wr_ist   = reg_wr && hit(reg_addr, dlf_pkg::OFS_IRQ_ST);
   wire wr_imsk  = reg_wr && hit(reg_addr, dlf_pkg::OFS_IRQ_MSK);

   // config registers; reserved bits masked off on write
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         decim_reg <= dlf_pkg::RST_DECIM;
         trim_reg  <= dlf_pkg::RST_TRIM;
         hold_reg  <= dlf_pkg::RST_HOLD;
         bw_reg    <= dlf_pkg::RST_BW;
         damp_reg  <= dlf_pkg::RST_DAMP;
         ctrl_reg  <= dlf_pkg::RST_CTRL;
      end
      else if (clk_en)
      begin
         if (wr_decim) decim_reg <= reg_wdata & dlf_pkg::MSK_DECIM;
         if (wr_trim)  trim_reg  <= reg_wdata & dlf_pkg::MSK_TRIM;
         if (wr_hold)  hold_reg  <= reg_wdata;
         if (wr_bw)    bw_reg    <= reg_wdata;
         if (wr_damp)  damp_reg  <= reg_wdata & dlf_pkg::MSK_DAMP;
         if (wr_ctrl)  ctrl_reg  <= reg_wdata & dlf_pkg::MSK_CTRL;
      end
   end

   // selector hookup
   assign sel_bus.bw_cfg     = bw_reg;
   assign sel_bus.damp_cfg   = damp_reg;
   assign sel_bus.auto_sel   = ctrl_reg[dlf_pkg::CTRL_AUTO_SEL];
   assign sel_bus.loop_state = dlf_pkg::dlf_loop_state_t'(loop_state_in);
   assign loop_bw_coarse     = sel_bus.bw_coarse;
   assign loop_bw_fine       = sel_bus.bw_fine;
   assign loop_damp_shift    = sel_bus.damp_shift;
   assign loop_damp_mult     = sel_bus.damp_mult;
   // software owns the freeze; the loop merely obeys it
   assign filter_freeze      = ctrl_reg[dlf_pkg::CTRL_FREEZE];

   // decimator: switch shift only when hitless and a switch is running
   wire use_switch = hitless_en && switch_active;
   assign decim_shift  = use_switch ? {1'b0, decim_reg[6:4]}
                                    : decim_reg[3:0];
   assign decim_bypass = (decim_shift == 4'h0);

   // trim read as signed byte
   assign xtal_trim_val = $signed(trim_reg[7:0]);

   // holdover filter, coarse clamped to its top code
   wire coarse_over = hold_reg[15:11] > dlf_pkg::HOLD_COARSE_MAX;
   assign hold_filter_coarse = coarse_over ? dlf_pkg::HOLD_COARSE_MAX
                                           : hold_reg[15:11];
   assign hold_filter_fine   = hold_reg[10:8];
   // either control at zero means infinite bandwidth
   assign hold_filter_bypass = (hold_reg[15:11] == 5'h00) ||
                               (hold_reg[10:8] == 3'h0);
   assign hold_history_sec   = hold_reg[7:4];

   // limit flag registered so software sees a stable level
   wire limit_now = unlock_count > {4'h0, hold_reg[3:0]};
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         limit_q <= 1'b0;
         acq_q   <= 1'b0;
      end
      else if (clk_en)
      begin
         limit_q <= limit_now;
         acq_q   <= sel_bus.acq_active;
      end
   end
   assign unlock_limit_flag = limit_q;

   // events: limit flag rise and parameter set change
   wire [IRQ_W_L-1:0] irq_evt;
   assign irq_evt[dlf_pkg::IRQ_UNLOCK_RISE] = limit_now && !limit_q;
   assign irq_evt[dlf_pkg::IRQ_STATE_CHG]   = sel_bus.acq_active != acq_q;

   // sticky status; a new event beats a same-cycle clear
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         irq_status <= '0;
         irq_mask   <= '0;
      end
      else if (clk_en)
      begin
         irq_status <= (irq_status &
                        ~(wr_ist ? reg_wdata[IRQ_W_L-1:0] : '0)) | irq_evt;
         if (wr_imsk) irq_mask <= reg_wdata[IRQ_W_L-1:0];
      end
   end
   assign irq = |(irq_status & irq_mask);

   // read mux; unmapped addresses read zero
   always_comb
   begin
      next_rdata = 16'h0000;
      case (reg_addr)
         dlf_pkg::OFS_DECIM:   next_rdata = decim_reg;
         dlf_pkg::OFS_TRIM:    next_rdata = trim_reg;
         dlf_pkg::OFS_HOLD:    next_rdata = hold_reg;
         dlf_pkg::OFS_BW:      next_rdata = bw_reg;
         dlf_pkg::OFS_DAMP:    next_rdata = damp_reg;
         dlf_pkg::OFS_CTRL:    next_rdata = ctrl_reg;
         dlf_pkg::OFS_STATUS:  next_rdata = {14'h0000, acq_q, limit_q};
         dlf_pkg::OFS_IRQ_ST:  next_rdata = {14'h0000, irq_status};
         dlf_pkg::OFS_IRQ_MSK: next_rdata = {14'h0000, irq_mask};
         default:              next_rdata = 16'h0000;
      endcase
   end

   // read data valid the cycle after the strobe only
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         reg_rdata <= 16'h0000;
      else if (clk_en)
         reg_rdata <= reg_rd ? next_rdata : 16'h0000;
   end

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   a_switch_shift_use: assert property (use_switch |->
      decim_shift == {1'b0, decim_reg[6:4]})
      else $error("switch shift not applied");
   a_hitless_off_ignore: assert property (!hitless_en |->
      decim_shift == decim_reg[3:0])
      else $error("switch shift used with hitless off");
   a_decim_zero_bypass: assert property ((use_switch ?
      decim_reg[6:4] == 3'h0 : decim_reg[3:0] == 4'h0) |-> decim_bypass)
      else $error("zero decimator shift not bypassed");
   a_coarse_sat_limit: assert property (hold_reg[15:11] > 5'h14 |->
      hold_filter_coarse == 5'h14)
      else $error("holdover coarse not clamped");
   a_hold_zero_bypass: assert property (hold_reg[10:8] == 3'h0 ||
      hold_reg[15:11] == 5'h00 |-> hold_filter_bypass)
      else $error("fine zero not bypassing");
   a_limit_flag_follow: assert property (clk_en ##1 1'b1 |->
      unlock_limit_flag == $past(limit_now))
      else $error("limit flag does not follow counter");
   a_acq_set_pick: assert property (sel_bus.acq_active |->
      loop_bw_coarse == bw_reg[15:11] && loop_damp_mult == damp_reg[10:8])
      else $error("acquire set not selected");
   a_normal_set_pick: assert property (!ctrl_reg[0] |->
      loop_bw_coarse == bw_reg[7:3] && loop_damp_shift == damp_reg[5:3])
      else $error("normal set not forced");
   a_reserved_read_zero: assert property (reg_rd && clk_en &&
      reg_addr == dlf_pkg::OFS_DAMP ##1 1'b1 |->
      (reg_rdata & 16'hc0c0) == 16'h0000)
      else $error("reserved damping bits not zero");
endmodule
`default_nettype wire

//--- test/dlf_cfg_bank_tb.sv
/*
 self-checking bench for the loop filter config bank: reset values,
 random register traffic with output field checks, limit flag, interrupts.
 assumes dlf_pkg is compiled first and the bank answers reads one cycle late.
*/
`timescale 1ns/1ps
`default_nettype none
module dlf_cfg_bank_tb;
   logic               ref_clk = 1'b0;
   logic               reset = 1'b1;
   logic               clk_en = 1'b1;
   logic [3:0]         reg_addr = 4'h0;
   logic [15:0]        reg_wdata = 16'h0000;
   logic               reg_wr = 1'b0;
   logic               reg_rd = 1'b0;
   logic               hitless_en = 1'b0;
   logic               switch_active = 1'b0;
   logic [1:0]         loop_state_in = 2'b00;
   logic [7:0]         unlock_count = 8'h00;
   logic [15:0]        reg_rdata;
   logic [3:0]         decim_shift;
   logic               decim_bypass;
   logic signed [7:0]  xtal_trim_val;
   logic [4:0]         hold_filter_coarse;
   logic [2:0]         hold_filter_fine;
   logic               hold_filter_bypass;
   logic [3:0]         hold_history_sec;
   logic               unlock_limit_flag;
   logic [4:0]         loop_bw_coarse;
   logic [2:0]         loop_bw_fine;
   logic [2:0]         loop_damp_shift;
   logic [2:0]         loop_damp_mult;
   logic               filter_freeze;
   logic               irq;
   logic [15:0]        shadow [0:5];
   logic [15:0]        d;
   int                 miscompares = 0;
   int                 checks = 0;
   int                 seed = 32'h0000_911c;

   // 200 MHz core clock
   always #2.5 ref_clk = ~ref_clk;

   dlf_cfg_bank dut
   (
      .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hitless_en(hitless_en),
      .switch_active(switch_active), .loop_state_in(loop_state_in),
      .unlock_count(unlock_count), .decim_shift(decim_shift),
      .decim_bypass(decim_bypass), .xtal_trim_val(xtal_trim_val),
      .hold_filter_coarse(hold_filter_coarse),
      .hold_filter_fine(hold_filter_fine),
      .hold_filter_bypass(hold_filter_bypass),
      .hold_history_sec(hold_history_sec),
      .unlock_limit_flag(unlock_limit_flag),
      .loop_bw_coarse(loop_bw_coarse), .loop_bw_fine(loop_bw_fine),
      .loop_damp_shift(loop_damp_shift), .loop_damp_mult(loop_damp_mult),
      .filter_freeze(filter_freeze), .irq(irq)
   );

   task finish_test;
      if (miscompares == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task check(input string       nm,
              input logic [15:0] seen,
              input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one-cycle strobes, launched right after an edge
   task wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   // writable bits per register; unmapped places hold nothing
   function automatic logic [15:0] msk(input logic [3:0] a);
      case (a)
         4'h0: return dlf_pkg::MSK_DECIM;
         4'h1: return dlf_pkg::MSK_TRIM;
         4'h2, 4'h3: return 16'hffff;
         4'h4: return dlf_pkg::MSK_DAMP;
         4'h5: return dlf_pkg::MSK_CTRL;
         default: return 16'h0000;
      endcase
   endfunction

   // expected field outputs worked out from the shadow copies
   task chk_outs;
      logic [15:0] h;
      logic [15:0] b;
      logic [15:0] m;
      logic [15:0] s;
      logic        acq;
      h = shadow[2];
      b = shadow[3];
      m = shadow[4];
      acq = shadow[5][0] && loop_state_in == dlf_pkg::DLF_ST_ACQUIRE;
      s = (hitless_en && switch_active) ? shadow[0][6:4] : shadow[0][3:0];
      check("decim_shift", 16'(decim_shift), s);
      check("decim_bypass", 16'(decim_bypass), 16'(s == 0));
      check("xtal_trim", 16'(xtal_trim_val),
            {{8{shadow[1][7]}}, shadow[1][7:0]});
      check("hold_coarse", 16'(hold_filter_coarse),
            (h[15:11] > 20) ? 16'h0014 : 16'(h[15:11]));
      check("hold_fine", 16'(hold_filter_fine), 16'(h[10:8]));
      check("hold_bypass", 16'(hold_filter_bypass),
            16'(h[15:11] == 0 || h[10:8] == 0));
      check("hold_history", 16'(hold_history_sec), 16'(h[7:4]));
      check("limit_flag", 16'(unlock_limit_flag),
            16'(unlock_count > h[3:0]));
      check("bw_coarse", 16'(loop_bw_coarse),
            acq ? 16'(b[15:11]) : 16'(b[7:3]));
      check("bw_fine", 16'(loop_bw_fine),
            acq ? 16'(b[10:8]) : 16'(b[2:0]));
      check("damp_shift", 16'(loop_damp_shift),
            acq ? 16'(m[13:11]) : 16'(m[5:3]));
      check("damp_mult", 16'(loop_damp_mult),
            acq ? 16'(m[10:8]) : 16'(m[2:0]));
      check("freeze", 16'(filter_freeze), 16'(shadow[5][1]));
   endtask

   // random inputs, one write, field check, then readback
   task step(input logic [3:0] a, input logic [15:0] v);
      logic [31:0] r;
      r = $random(seed);
      @(posedge ref_clk);
      hitless_en <= r[0];
      switch_active <= r[1];
      loop_state_in <= r[3:2];
      unlock_count <= r[11:4];
      wr(a, v);
      if (a <= 4'h5)
         shadow[a] = v & msk(a);
      @(posedge ref_clk);
      #1 chk_outs;
      rd(a, d);
      check("readback", d, (a <= 4'h5) ? shadow[a] : 16'h0000);
   endtask

   // hang guard, far beyond the few hundred cycles the run needs
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      finish_test;
   end

   initial
   begin
      logic [15:0] rst_tab [0:8];
      logic [31:0] r;
      rst_tab = '{dlf_pkg::RST_DECIM, dlf_pkg::RST_TRIM, dlf_pkg::RST_HOLD,
                  dlf_pkg::RST_BW, dlf_pkg::RST_DAMP, dlf_pkg::RST_CTRL,
                  16'h0000, 16'h0000, 16'h0000};
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      // reset values, unmapped place reads zero
      for (int i = 0; i < 9; i++)
      begin
         rd(4'(i), d);
         check("rst", d, rst_tab[i]);
      end
      rd(4'hf, d);
      check("unmapped", d, 16'h0000);
      for (int i = 0; i < 6; i++)
         shadow[i] = rst_tab[i];
      #1 chk_outs;
      // corners: clamp edges, zero bypass, full reserved bits
      step(4'h2, 16'ha800);
      step(4'h2, 16'hf8ff);
      step(4'h2, 16'ha0a5);
      step(4'h2, 16'h07a0);
      step(4'h0, 16'hff80);
      step(4'h4, 16'hffff);
      step(4'h5, 16'hfffe);
      step(4'h9, 16'hffff);
      for (int n = 0; n < 40; n++)
      begin
         r = $random(seed);
         step((r[3:0] > 4'h5 && r[3:0] < 4'h9) ? 4'h3 : r[3:0], r[31:16]);
      end
      // frozen clock enable keeps the registers
      @(posedge ref_clk);
      clk_en <= 1'b0;
      wr(4'h1, 16'h00a5);
      clk_en <= 1'b1;
      rd(4'h1, d);
      check("clk_en_hold", d, shadow[1]);
      // limit flag rising edge interrupt, mask and clear
      @(posedge ref_clk);
      loop_state_in <= dlf_pkg::DLF_ST_FREERUN;
      unlock_count <= 8'h05;
      wr(4'h5, 16'h0003);
      #1 check("freeze_on", 16'(filter_freeze), 16'h0001);
      wr(4'h2, 16'h3805);
      wr(4'h5, 16'h0001);
      wr(4'h8, 16'h0001);
      wr(4'h7, 16'h0003);
      #1 check("irq_idle", 16'(irq), 16'h0000);
      @(posedge ref_clk);
      unlock_count <= 8'h06;
      repeat (3) @(posedge ref_clk);
      #1 check("irq_rise", 16'(irq), 16'h0001);
      rd(4'h6, d);
      check("status", d, 16'h0001);
      wr(4'h7, 16'h0001);
      #1 check("irq_clear", 16'(irq), 16'h0000);
      wr(4'h8, 16'h0002);
      unlock_count <= 8'h00;
      repeat (3) @(posedge ref_clk);
      unlock_count <= 8'h06;
      repeat (3) @(posedge ref_clk);
      #1 check("irq_masked", 16'(irq), 16'h0000);
      wr(4'h7, 16'h0003);
      // parameter set change raises the second event
      loop_state_in <= dlf_pkg::DLF_ST_ACQUIRE;
      repeat (3) @(posedge ref_clk);
      #1 check("irq_set_chg", 16'(irq), 16'h0001);
      rd(4'h7, d);
      check("irq_status", d, 16'h0002);
      rd(4'h6, d);
      check("status_acq", d, 16'h0003);
      finish_test;
   end
endmodule
`default_nettype wire
